// ==== src/aci_pkg.sv ====
// shared constants and types of the accumulator command interpreter
`default_nettype none
package aci_pkg;
    // frame: addr, instr, type, bank, value msb first, checksum
    localparam int          FRM_LEN    = 9;
    localparam logic [3:0]  FRM_LAST   = 4'h8;
    localparam int          POS_ADDR   = 0;
    localparam int          POS_INSTR  = 1;
    localparam int          POS_TYPE   = 2;
    localparam int          POS_BANK   = 3;
    localparam int          POS_VAL3   = 4;
    localparam int          POS_VAL2   = 5;
    localparam int          POS_VAL1   = 6;
    localparam int          POS_VAL0   = 7;
    localparam int          POS_CSUM   = 8;
    // instruction codes
    localparam logic [7:0]  INS_SET_OUTPUT = 8'h0e;
    localparam logic [7:0]  INS_READ_PORT  = 8'h0f;
    localparam logic [7:0]  INS_ARITH      = 8'h13;
    localparam logic [7:0]  INS_COMPARE    = 8'h14;
    localparam logic [7:0]  INS_COND_JUMP  = 8'h15;
    // banks and ports
    localparam logic [7:0]  BANK_DIGIN     = 8'h00;
    localparam logic [7:0]  BANK_ANALOG    = 8'h01;
    localparam logic [7:0]  BANK_DIGOUT    = 8'h02;
    localparam logic [7:0]  PORT_HOME      = 8'h00;
    localparam logic [7:0]  PORT_DRV_EN    = 8'h01;
    localparam logic [7:0]  PORT_ALL       = 8'hff;
    localparam logic [31:0] VAL_FROM_ACC   = 32'hffff_ffff;
    // arithmetic operations
    localparam logic [7:0]  OP_ADD  = 8'h00;
    localparam logic [7:0]  OP_SUB  = 8'h01;
    localparam logic [7:0]  OP_MUL  = 8'h02;
    localparam logic [7:0]  OP_DIV  = 8'h03;
    localparam logic [7:0]  OP_MOD  = 8'h04;
    localparam logic [7:0]  OP_AND  = 8'h05;
    localparam logic [7:0]  OP_OR   = 8'h06;
    localparam logic [7:0]  OP_XOR  = 8'h07;
    localparam logic [7:0]  OP_NOT  = 8'h08;
    localparam logic [7:0]  OP_LOAD = 8'h09;
    // jump conditions
    localparam logic [7:0]  CND_ZE = 8'h00;
    localparam logic [7:0]  CND_NZ = 8'h01;
    localparam logic [7:0]  CND_EQ = 8'h02;
    localparam logic [7:0]  CND_NE = 8'h03;
    localparam logic [7:0]  CND_GT = 8'h04;
    localparam logic [7:0]  CND_GE = 8'h05;
    localparam logic [7:0]  CND_LT = 8'h06;
    localparam logic [7:0]  CND_LE = 8'h07;
    // reply status codes
    localparam logic [7:0]  STS_OK      = 8'h64;
    localparam logic [7:0]  STS_CSUM    = 8'h01;
    localparam logic [7:0]  STS_BAD_CMD = 8'h02;
    localparam logic [7:0]  STS_BAD_TYP = 8'h03;
    localparam logic [7:0]  STS_BAD_VAL = 8'h04;
    // register byte offsets
    localparam logic [4:0]  REG_CTRL   = 5'h00;
    localparam logic [4:0]  REG_ACC    = 5'h04;
    localparam logic [4:0]  REG_FLAGS  = 5'h08;
    localparam logic [4:0]  REG_OUTS   = 5'h0c;
    localparam logic [4:0]  REG_STATUS = 5'h10;
    // ctrl fields and reset values
    localparam int          CTRL_MOD_LSB  = 0;
    localparam int          CTRL_HOST_LSB = 8;
    localparam logic [7:0]  RST_MOD_ADDR  = 8'h01;
    localparam logic [7:0]  RST_HOST_ADDR = 8'h02;
    // flag fields
    localparam int          FLG_ZERO = 0;
    localparam int          FLG_EQ   = 1;
    localparam int          FLG_GT   = 2;
    localparam int          FLG_LT   = 3;

    typedef enum logic [1:0] {
        S_IDLE,
        S_EXEC,
        S_TX
    } aci_fsm_t;
endpackage
`default_nettype wire

// ==== src/aci_core.sv ====
// accumulator command interpreter: read port, arithmetic, compare, jump flags
`default_nettype none
module aci_core
    import aci_pkg::*;
#(
    parameter int NOUT   = 1,
    parameter int ADC_CH = 2,
    parameter int ADC_W  = 12
) (
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         srst,
    // avalon-mm register slave
    input  wire logic [4:0]                   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output var  logic [31:0]                  avs_readdata,
    output var  logic                         avs_waitrequest,
    // direct-mode byte stream from the serial receiver
    input  wire logic                         rx_valid,
    input  wire logic [7:0]                   rx_data,
    output var  logic                         rx_ready,
    // reply byte stream to the serial transmitter
    output var  logic                         tx_valid,
    output var  logic [7:0]                   tx_data,
    input  wire logic                         tx_ready,
    // stored-program command port
    input  wire logic                         prog_valid,
    input  wire logic [7:0]                   prog_instr,
    input  wire logic [7:0]                   prog_type,
    input  wire logic [7:0]                   prog_bank,
    input  wire logic [31:0]                  prog_value,
    output var  logic                         prog_ready,
    // jump decision back to the program sequencer
    output var  logic                         jump_valid,
    output var  logic                         jump_taken,
    output var  logic [31:0]                  jump_addr,
    // pins and converter
    input  wire logic                         home_sw,
    input  wire logic                         drv_en,
    input  wire logic [ADC_CH-1:0][ADC_W-1:0] adc_data,
    output var  logic [NOUT-1:0]              out_lines
);

    if (NOUT < 1 || NOUT > 32 || ADC_CH < 1 || ADC_CH > 255 || ADC_W < 1 || ADC_W > 32)
    begin : g_param_chk
        $error("aci_core: parameter out of range");
    end

    typedef struct packed {
        aci_fsm_t         fsm;
        logic [3:0]       cnt;
        logic [8:0][7:0]  frm;
        logic [8:0][7:0]  rep;
        logic [31:0]      acc;
        logic             f_zero;
        logic             f_eq;
        logic             f_gt;
        logic             f_lt;
        logic [NOUT-1:0]  outs;
        logic             home_s1;
        logic             home_s2;
        logic             en_s1;
        logic             en_s2;
        logic             jmp_vld;
        logic             jmp_tkn;
        logic [31:0]      jmp_addr;
        logic             bus_ack;
        logic [31:0]      rdata;
        logic [7:0]       mod_addr;
        logic [7:0]       host_addr;
        logic [7:0]       last_sts;
    } aci_state_t;

    aci_state_t st_ff;
    aci_state_t nxt_st;

    // command source: frame in S_EXEC, else program port
    logic        from_frame;
    logic [7:0]  c_instr;
    logic [7:0]  c_type;
    logic [7:0]  c_bank;
    logic [31:0] c_val;
    logic [7:0]  frm_sum;
    logic        frm_ok;

    assign from_frame = (st_ff.fsm == S_EXEC);
    assign c_instr    = from_frame ? st_ff.frm[POS_INSTR] : prog_instr;
    assign c_type     = from_frame ? st_ff.frm[POS_TYPE]  : prog_type;
    assign c_bank     = from_frame ? st_ff.frm[POS_BANK]  : prog_bank;
    // value arrives most significant byte first
    assign c_val      = from_frame ? {st_ff.frm[POS_VAL3], st_ff.frm[POS_VAL2],
                                      st_ff.frm[POS_VAL1], st_ff.frm[POS_VAL0]}
                                   : prog_value;

    function automatic logic [7:0] byte_sum(input logic [8:0][7:0] b, input int n);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < n; i++) begin
            s = s + b[i];
        end
        return s;
    endfunction

    assign frm_sum = byte_sum(st_ff.frm, POS_CSUM);
    assign frm_ok  = (frm_sum == st_ff.frm[POS_CSUM]);

    // port read
    logic [31:0] port_val;
    logic        port_ok;

    always_comb begin
        port_val = 32'h0000_0000;
        port_ok  = 1'b0;
        case (c_bank)
            BANK_DIGIN: begin
                if (c_type == PORT_HOME) begin
                    port_val = {31'h0000_0000, st_ff.home_s2};
                    port_ok  = 1'b1;
                end else if (c_type == PORT_DRV_EN) begin
                    port_val = {31'h0000_0000, st_ff.en_s2};
                    port_ok  = 1'b1;
                end
            end
            BANK_ANALOG: begin
                for (int i = 0; i < ADC_CH; i++) begin
                    if (c_type == 8'(i)) begin
                        port_val = 32'(adc_data[i]);
                        port_ok  = 1'b1;
                    end
                end
            end
            BANK_DIGOUT: begin
                for (int i = 0; i < NOUT; i++) begin
                    if (c_type == 8'(i)) begin
                        port_val = {31'h0000_0000, st_ff.outs[i]};
                        port_ok  = 1'b1;
                    end
                end
            end
            default: begin
                port_ok = 1'b0;
            end
        endcase
    end

    // arithmetic on the accumulator, signed for add, sub, mul, div and mod, bitwise for and, or, xor and not
    logic signed [31:0] acc_s;
    logic signed [31:0] opd_s;
    logic        [31:0] ar_res;
    logic        [7:0]  ar_sts;

    assign acc_s = signed'(st_ff.acc);
    assign opd_s = signed'(c_val);

    always_comb begin
        ar_res = st_ff.acc;
        ar_sts = STS_OK;
        case (c_type)
            OP_ADD:  ar_res = 32'(acc_s + opd_s);
            OP_SUB:  ar_res = 32'(acc_s - opd_s);
            OP_MUL:  ar_res = 32'(acc_s * opd_s);
            OP_DIV: begin
                if (c_val == 32'h0000_0000) begin
                    ar_sts = STS_BAD_VAL;
                end else begin
                    ar_res = 32'(acc_s / opd_s);
                end
            end
            OP_MOD: begin
                if (c_val == 32'h0000_0000) begin
                    ar_sts = STS_BAD_VAL;
                end else begin
                    ar_res = 32'(acc_s % opd_s);
                end
            end
            OP_AND:  ar_res = st_ff.acc & c_val;
            OP_OR:   ar_res = st_ff.acc | c_val;
            OP_XOR:  ar_res = st_ff.acc ^ c_val;
            OP_NOT:  ar_res = ~st_ff.acc;
            OP_LOAD: ar_res = c_val;
            default: ar_sts = STS_BAD_TYP;
        endcase
    end

    // jump condition from the flags of the last compare; zero flag also set by the last arithmetic
    logic cond_hit;

    always_comb begin
        case (c_type)
            CND_ZE:  cond_hit = st_ff.f_zero;
            CND_NZ:  cond_hit = !st_ff.f_zero;
            CND_EQ:  cond_hit = st_ff.f_eq;
            CND_NE:  cond_hit = !st_ff.f_eq;
            CND_GT:  cond_hit = st_ff.f_gt;
            CND_GE:  cond_hit = st_ff.f_gt || st_ff.f_eq;
            CND_LT:  cond_hit = st_ff.f_lt;
            CND_LE:  cond_hit = st_ff.f_lt || st_ff.f_eq;
            default: cond_hit = 1'b0;
        endcase
    end

    logic prog_take;

    assign prog_ready = (st_ff.fsm == S_IDLE) && !rx_valid;
    assign prog_take  = prog_valid && prog_ready;
    assign rx_ready   = (st_ff.fsm == S_IDLE);

    always_comb begin
        logic        run;
        logic [7:0]  sts;
        logic [31:0] rval;
        logic [8:0][7:0] rb;
        run    = 1'b0;
        sts    = STS_OK;
        rval   = 32'h0000_0000;
        rb     = '0;
        nxt_st = st_ff;

        // pin synchronisers
        nxt_st.home_s1 = home_sw;
        nxt_st.home_s2 = st_ff.home_s1;
        nxt_st.en_s1   = drv_en;
        nxt_st.en_s2   = st_ff.en_s1;
        nxt_st.jmp_vld = 1'b0;

        // register bus: one wait state, write lands on the acknowledging edge
        nxt_st.bus_ack = (avs_read || avs_write) && !st_ff.bus_ack;
        if (avs_read && !st_ff.bus_ack) begin
            case (avs_address)
                REG_CTRL:   nxt_st.rdata = {16'h0000, st_ff.host_addr, st_ff.mod_addr};
                REG_ACC:    nxt_st.rdata = st_ff.acc;
                REG_FLAGS:  nxt_st.rdata = {28'h0000_000, st_ff.f_lt, st_ff.f_gt,
                                            st_ff.f_eq, st_ff.f_zero};
                REG_OUTS:   nxt_st.rdata = 32'(st_ff.outs);
                REG_STATUS: nxt_st.rdata = {22'h00_0000, st_ff.fsm, st_ff.last_sts};
                default:    nxt_st.rdata = 32'h0000_0000;
            endcase
        end
        if (avs_write && st_ff.bus_ack) begin
            if (avs_address == REG_CTRL) begin
                if (avs_byteenable[0]) nxt_st.mod_addr = avs_writedata[CTRL_MOD_LSB +: 8];
                if (avs_byteenable[1]) nxt_st.host_addr = avs_writedata[CTRL_HOST_LSB +: 8];
            end else if (avs_address == REG_ACC) begin
                for (int i = 0; i < 4; i++) begin
                    if (avs_byteenable[i]) nxt_st.acc[8*i +: 8] = avs_writedata[8*i +: 8];
                end
            end
        end

        case (st_ff.fsm)
            S_IDLE: begin
                if (rx_valid) begin
                    nxt_st.frm[st_ff.cnt] = rx_data;
                    if (st_ff.cnt == FRM_LAST) begin
                        nxt_st.cnt = 4'h0;
                        nxt_st.fsm = S_EXEC;
                    end else begin
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                    end
                end else if (prog_take) begin
                    run = 1'b1;
                end
            end
            S_EXEC: begin
                // foreign frames dropped, no reply
                if (st_ff.frm[POS_ADDR] != st_ff.mod_addr) begin
                    nxt_st.fsm = S_IDLE;
                end else begin
                    if (!frm_ok) begin
                        sts = STS_CSUM;
                    end else begin
                        run = 1'b1;
                    end
                    nxt_st.fsm = S_TX;
                end
            end
            S_TX: begin
                if (tx_ready) begin
                    nxt_st.rep = {8'h00, st_ff.rep[8:1]};
                    if (st_ff.cnt == FRM_LAST) begin
                        nxt_st.cnt = 4'h0;
                        nxt_st.fsm = S_IDLE;
                    end else begin
                        nxt_st.cnt = st_ff.cnt + 4'h1;
                    end
                end
            end
            default: begin
                nxt_st.fsm = S_IDLE;
                nxt_st.cnt = 4'h0;
            end
        endcase

        // command execution, shared by both sources; beats a bus write to acc
        if (run) begin
            case (c_instr)
                INS_READ_PORT: begin
                    if (!port_ok) begin
                        sts = STS_BAD_TYP;
                    end else if (from_frame) begin
                        rval = port_val;
                    end else begin
                        nxt_st.acc = port_val;
                    end
                end
                INS_ARITH: begin
                    sts  = ar_sts;
                    rval = c_val;
                    if (ar_sts == STS_OK) begin
                        nxt_st.acc    = ar_res;
                        nxt_st.f_zero = (ar_res == 32'h0000_0000);
                    end
                end
                INS_COMPARE: begin
                    rval         = c_val;
                    nxt_st.f_eq  = (acc_s == opd_s);
                    nxt_st.f_zero = (acc_s == opd_s);
                    nxt_st.f_gt  = (acc_s > opd_s);
                    nxt_st.f_lt  = (acc_s < opd_s);
                end
                INS_SET_OUTPUT: begin
                    if (c_bank != BANK_DIGOUT) begin
                        sts = STS_BAD_TYP;
                    end else if (c_type == PORT_ALL) begin
                        // all lines at once, from acc when value is -1
                        nxt_st.outs = (c_val == VAL_FROM_ACC) ? st_ff.acc[NOUT-1:0]
                                                              : c_val[NOUT-1:0];
                    end else if (c_type < 8'(NOUT)) begin
                        for (int i = 0; i < NOUT; i++) begin
                            if (c_type == 8'(i)) nxt_st.outs[i] = c_val[0];
                        end
                    end else begin
                        sts = STS_BAD_TYP;
                    end
                end
                INS_COND_JUMP: begin
                    if (from_frame) begin
                        sts = STS_BAD_CMD;
                    end else begin
                        nxt_st.jmp_vld  = 1'b1;
                        nxt_st.jmp_tkn  = cond_hit;
                        nxt_st.jmp_addr = c_val;
                    end
                end
                default: sts = STS_BAD_CMD;
            endcase
        end

        // reply frame with trailing checksum
        if (from_frame && st_ff.frm[POS_ADDR] == st_ff.mod_addr) begin
            rb[POS_ADDR]  = st_ff.host_addr;
            rb[POS_INSTR] = st_ff.mod_addr;
            rb[POS_TYPE]  = sts;
            rb[POS_BANK]  = st_ff.frm[POS_INSTR];
            rb[POS_VAL3]  = rval[31:24];
            rb[POS_VAL2]  = rval[23:16];
            rb[POS_VAL1]  = rval[15:8];
            rb[POS_VAL0]  = rval[7:0];
            rb[POS_CSUM]  = byte_sum(rb, POS_CSUM);
            nxt_st.rep      = rb;
            nxt_st.last_sts = sts;
        end else if (run) begin
            nxt_st.last_sts = sts;
        end

        if (srst) begin
            nxt_st           = '0;
            nxt_st.fsm       = S_IDLE;
            nxt_st.mod_addr  = RST_MOD_ADDR;
            nxt_st.host_addr = RST_HOST_ADDR;
            nxt_st.last_sts  = STS_OK;
        end
    end

    always_ff @(posedge mclk) begin
        st_ff <= nxt_st;
    end

    assign avs_waitrequest = (avs_read || avs_write) && !st_ff.bus_ack;
    assign avs_readdata    = st_ff.rdata;
    assign tx_valid        = (st_ff.fsm == S_TX);
    assign tx_data         = st_ff.rep[0];
    assign jump_valid      = st_ff.jmp_vld;
    assign jump_taken      = st_ff.jmp_tkn;
    assign jump_addr       = st_ff.jmp_addr;
    assign out_lines       = st_ff.outs;

endmodule
`default_nettype wire

// ==== bench/aci_core_asserts.sv ====
// port assertions of the accumulator command interpreter
`default_nettype none
module aci_core_asserts
    import aci_pkg::*;
#(
    parameter int NOUT = 1
) (
    // clock and reset
    input wire logic            mclk,
    input wire logic            srst,
    // watched ports
    input wire logic            avs_read,
    input wire logic            avs_write,
    input wire logic            avs_waitrequest,
    input wire logic            rx_valid,
    input wire logic            rx_ready,
    input wire logic            tx_valid,
    input wire logic [7:0]      tx_data,
    input wire logic            tx_ready,
    input wire logic            prog_valid,
    input wire logic [7:0]      prog_instr,
    input wire logic            prog_ready,
    input wire logic            jump_valid,
    input wire logic [NOUT-1:0] out_lines
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    a_wait_one: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1
        !avs_waitrequest) else $error("wait state wrong");
    a_wait_idle: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
        else $error("stray waitrequest");
    a_rx_busy: assert property (tx_valid |-> !rx_ready && !prog_ready)
        else $error("busy during reply");
    a_prog_block: assert property (rx_valid |-> !prog_ready) else $error("prog not held");
    a_jump_pulse: assert property (jump_valid |=> !jump_valid)
        else $error("long jump pulse");
    a_jump_cause: assert property (jump_valid |-> $past(prog_valid && prog_ready &&
        prog_instr == INS_COND_JUMP)) else $error("stray jump");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte moved");
    a_reply_lat: assert property ($rose(tx_valid) |-> $past(!rx_ready && !tx_valid) &&
        $past(rx_ready, 2)) else $error("reply latency");
    a_out_cause: assert property ($changed(out_lines) |-> $past(prog_valid && prog_ready &&
        prog_instr == INS_SET_OUTPUT) || $past(!rx_ready && !tx_valid))
        else $error("stray output");
endmodule
bind aci_core aci_core_asserts #(.NOUT(NOUT)) aci_core_asserts_i (.mclk(mclk), .srst(srst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .prog_valid(prog_valid), .prog_instr(prog_instr),
    .prog_ready(prog_ready), .jump_valid(jump_valid), .out_lines(out_lines));
`default_nettype wire

// ==== bench/aci_host_model.sv ====
// host model: sends command frames and collects reply frames
`default_nettype none
module aci_host_model
    import aci_pkg::*;
(
    // clock
    input  wire logic       mclk,
    // command bytes to the device
    output var  logic       rx_valid,
    output var  logic [7:0] rx_data,
    input  wire logic       rx_ready,
    // reply bytes from the device
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output var  logic       tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int         hangs = 0;
    logic [7:0] rep [9];
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end
    task automatic xfer(input logic [7:0] ins, typ, bnk, input logic [31:0] val, input int stall);
        logic [7:0] frm [9];
        int         n;
        frm = '{RST_MOD_ADDR, ins, typ, bnk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        for (int i = 0; i < 8; i++) frm[8] += frm[i];
        @(posedge mclk);
        foreach (frm[i]) begin
            rx_valid <= 1'b1;
            rx_data  <= frm[i];
            n = 0;
            do begin @(posedge mclk); n++; end while (!rx_ready && n < 50);
            if (n >= 50) hangs++;
        end
        rx_valid <= 1'b0;
        // idle line shows the inverse
        rx_data  <= ~frm[8];
        tx_ready <= (stall == 0);
        for (int i = 0; i < 9; i++) begin
            if (stall > 0) begin
                repeat (stall) @(posedge mclk);
                tx_ready <= 1'b1;
            end
            n = 0;
            do begin @(posedge mclk); n++; end while (!tx_valid && n < 50);
            if (n >= 50) hangs++;
            rep[i] = tx_data;
            tx_ready <= (stall == 0);
        end
    endtask
endmodule
`default_nettype wire

// ==== bench/aci_core_bench.sv ====
// self-checking bench of the accumulator command interpreter
`default_nettype none
module aci_core_bench
    import aci_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, srst = 1'b1, avs_read, avs_write, avs_waitrequest, rx_valid, rx_ready;
    logic tx_valid, tx_ready, prog_valid, prog_ready, jump_valid, jump_taken, home_sw, drv_en;
    logic [4:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [7:0]  rx_data, tx_data, prog_instr, prog_type, prog_bank;
    logic [31:0] avs_writedata, avs_readdata, prog_value, jump_addr, rd;
    logic [1:0][11:0] adc_data;
    logic [0:0]  out_lines;
    int          n_errors = 0, samples_checked = 0;
    logic [7:0]  ops [10] = '{OP_LOAD, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MOD, OP_AND, OP_OR,
        OP_XOR, OP_NOT};
    logic [31:0] opnd [10] = '{100, 5, 10, 32'hffff_fffd, 7, 7, 32'hff, 32'h100, 3, 0};
    logic [31:0] accx [10] = '{32'h64, 32'h69, 32'h5f, 32'hffff_fee3, 32'hffff_ffd8,
        32'hffff_fffb, 32'hfb, 32'h1fb, 32'h1f8, 32'hffff_fe07};
    logic [31:0] cmpv [2] = '{1000, 32'hffff_fe07};
    logic [7:0]  flgx [2] = '{8'h08, 8'h03};
    logic [7:0]  jtx [2] = '{8'hca, 8'ha5};
    initial forever #5 mclk = ~mclk;
    aci_core aci_core_i (.mclk(mclk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .prog_valid(prog_valid), .prog_instr(prog_instr), .prog_type(prog_type),
        .prog_bank(prog_bank), .prog_value(prog_value), .prog_ready(prog_ready),
        .jump_valid(jump_valid), .jump_taken(jump_taken), .jump_addr(jump_addr),
        .home_sw(home_sw), .drv_en(drv_en), .adc_data(adc_data), .out_lines(out_lines));
    aci_host_model host_i (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    task automatic final_report();
        if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        n = 0;
        do begin @(posedge mclk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin n_errors++; final_report(); end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic prog(input logic [7:0] ins, typ, bnk, input logic [31:0] val);
        int n;
        @(posedge mclk);
        prog_valid <= 1'b1;
        prog_instr <= ins;
        prog_type  <= typ;
        prog_bank  <= bnk;
        prog_value <= val;
        n = 0;
        do begin @(posedge mclk); n++; end while (prog_ready !== 1'b1 && n < 50);
        if (n >= 50) begin n_errors++; final_report(); end
        prog_valid <= 1'b0;
    endtask
    task automatic dir(input logic [7:0] ins, typ, bnk, input logic [31:0] val, input int stall,
                       input logic [31:0] xv);
        logic [7:0] s = 8'h00;
        host_i.xfer(ins, typ, bnk, val, stall);
        if (host_i.hangs != 0) begin n_errors++; final_report(); end
        for (int i = 0; i < 8; i++) s += host_i.rep[i];
        chk("reply host", 32'(host_i.rep[0]), 32'(RST_HOST_ADDR));
        chk("reply target", 32'(host_i.rep[1]), 32'(RST_MOD_ADDR));
        chk("reply status", 32'(host_i.rep[2]), 32'(STS_OK));
        chk("reply instr", 32'(host_i.rep[3]), 32'(ins));
        chk("reply value", {host_i.rep[4], host_i.rep[5], host_i.rep[6], host_i.rep[7]}, xv);
        chk("reply checksum", 32'(host_i.rep[8]), 32'(s));
    endtask
    initial begin
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {prog_valid, prog_instr, prog_type, prog_bank, prog_value} = '0;
        {home_sw, drv_en, avs_byteenable} = 6'h3f;
        adc_data = {12'h0a5, 12'h12e};
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        bus(1'b0, REG_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h0000_0201);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped read", rd, 32'h0);
        bus(1'b1, REG_ACC, 32'h0000_0007);
        bus(1'b0, REG_ACC, 32'h0);
        chk("acc write", rd, 32'h0000_0007);
        for (int i = 0; i < 10; i++) begin
            prog(INS_ARITH, ops[i], 8'h00, opnd[i]);
            bus(1'b0, REG_ACC, 32'h0);
            chk("arith result", rd, accx[i]);
        end
        for (int k = 0; k < 2; k++) begin
            prog(INS_COMPARE, 8'h00, 8'h00, cmpv[k]);
            bus(1'b0, REG_FLAGS, 32'h0);
            chk("compare flags", rd, 32'(flgx[k]));
            for (int c = 0; c < 8; c++) begin
                prog(INS_COND_JUMP, 8'(c), 8'h00, 32'h10 + c);
                @(posedge mclk);
                chk("jump valid", 32'(jump_valid), 32'h1);
                chk("jump taken", 32'(jump_taken), 32'(jtx[k][c]));
                if (jtx[k][c]) chk("jump addr", jump_addr, 32'h10 + c);
            end
        end
        dir(INS_READ_PORT, PORT_HOME, BANK_DIGIN, 32'h5, 0, 32'h1);
        bus(1'b0, REG_ACC, 32'h0);
        chk("acc after direct read", rd, 32'hffff_fe07);
        dir(INS_READ_PORT, 8'h00, BANK_ANALOG, 32'h0, 2, 32'h12e);
        dir(INS_READ_PORT, 8'h01, BANK_ANALOG, 32'h0, 1, 32'h0a5);
        prog(INS_READ_PORT, PORT_DRV_EN, BANK_DIGIN, 32'h0);
        bus(1'b0, REG_ACC, 32'h0);
        chk("acc from program read", rd, 32'h1);
        prog(INS_SET_OUTPUT, PORT_ALL, BANK_DIGOUT, VAL_FROM_ACC);
        bus(1'b0, REG_OUTS, 32'h0);
        chk("outputs from acc", rd, 32'h1);
        dir(INS_READ_PORT, 8'h00, BANK_DIGOUT, 32'h0, 0, 32'h1);
        prog(INS_SET_OUTPUT, 8'h00, BANK_DIGOUT, 32'h0);
        @(posedge mclk);
        chk("output line zero", 32'(out_lines), 32'h0);
        dir(INS_READ_PORT, 8'h00, BANK_DIGOUT, 32'h0, 1, 32'h0);
        dir(INS_ARITH, OP_LOAD, 8'h00, 32'h1234_5678, 1, 32'h1234_5678);
        bus(1'b0, REG_ACC, 32'h0);
        chk("acc after direct load", rd, 32'h1234_5678);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
